// ---- hdl/cbwic_top.sv ----
`timescale 1ns/10ps
// bus cycle, wait-state and interrupt entry control of the processor core
module cbwic_top (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // pins
    input  wire logic        i_phase_one_clock,
    input  wire logic        i_phase_two_clock,
    input  wire logic        i_data_output_gate,
    input  wire logic        i_halt_release,
    input  wire logic        i_maskable_irq_n,
    input  wire logic        i_nonmaskable_irq_n,
    input  wire logic [7:0]  i_data_lines,
    output logic      [7:0]  o_data_lines,
    output logic             o_data_lines_oe,
    output logic      [15:0] o_address_lines,
    output logic             o_transfer_direction,
    output logic             o_opcode_fetch_marker,
    // core side
    input  wire logic [15:0] i_req_addr,
    input  wire logic        i_req_write,
    input  wire logic [7:0]  i_req_wdata,
    input  wire logic        i_req_fetch,
    input  wire logic        i_req_last,
    input  wire logic [15:0] i_core_pc,
    input  wire logic [7:0]  i_core_status,
    input  wire logic [7:0]  i_core_sp,
    input  wire logic        i_core_mask,
    output logic             o_cycle_done,
    output logic      [7:0]  o_read_data,
    output logic             o_halted,
    output logic             o_seq_active,
    output logic             o_sp_dec,
    output logic             o_set_mask,
    output logic             o_pc_load,
    output logic      [15:0] o_new_pc
);
    logic [cbwic_pkg::IN_W-1:0] in_s;
    logic              p1_s, p2_s, gate_s, rel_s, irq_n_s, nmi_n_s;
    logic [7:0]        data_s;
    logic              p1_prev_q, p2_prev_q, nmi_prev_q;
    logic              p1_rise, p2_fall;
    logic              bus_write_q, last_q, hold_q;
    logic              nmi_pend_q, nmi_type_q;
    logic [7:0]        sp_q, status_q;
    logic [15:0]       pc_q;
    logic              halt_now, take_int;
    logic [15:0]       seq_addr;
    logic [7:0]        seq_wdata;
    cbwic_pkg::cbwic_seq_t state_q;

    // all pins arrive from outside the clock domain
    cbwic_sync #(
        .W       (cbwic_pkg::IN_W),
        .RST_VAL (cbwic_pkg::IN_RST)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async ({i_phase_one_clock, i_phase_two_clock,
                   i_data_output_gate, i_halt_release,
                   i_maskable_irq_n, i_nonmaskable_irq_n, i_data_lines}),
        .o_sync  (in_s)
    );

    assign p1_s    = in_s[cbwic_pkg::IN_P1];
    assign p2_s    = in_s[cbwic_pkg::IN_P2];
    assign gate_s  = in_s[cbwic_pkg::IN_GATE];
    assign rel_s   = in_s[cbwic_pkg::IN_REL];
    assign irq_n_s = in_s[cbwic_pkg::IN_IRQ];
    assign nmi_n_s = in_s[cbwic_pkg::IN_NMI];
    assign data_s  = in_s[cbwic_pkg::IN_DATA_LO +: 8];

    // phase edges mark cycle start and cycle end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            p1_prev_q  <= 1'b0;
            p2_prev_q  <= 1'b0;
            nmi_prev_q <= 1'b1;
        end else begin
            p1_prev_q  <= p1_s;
            p2_prev_q  <= p2_s;
            nmi_prev_q <= nmi_n_s;
        end
    end
    assign p1_rise = p1_s & ~p1_prev_q;
    assign p2_fall = p2_prev_q & ~p2_s;

    // release level is steady across phase two, so its level at the
    // phase-two end equals its level since phase one
    assign halt_now = ~bus_write_q & ~rel_s;  // [RULE_06] [RULE_08]
    // requests sampled at the phase-two end of an instruction's last cycle
    assign take_int = last_q & rel_s &              // [RULE_14] [RULE_20]
                      (nmi_pend_q | (~irq_n_s & ~i_core_mask)); // [RULE_10]

    // sequencer address and data for the stack pushes and vector reads
    always_comb begin
        seq_addr  = {cbwic_pkg::STACK_PAGE, sp_q};          // [RULE_11]
        seq_wdata = status_q;
        case (state_q)
            cbwic_pkg::SEQ_PUSH_HI: seq_wdata = pc_q[15:8];
            cbwic_pkg::SEQ_PUSH_LO: seq_wdata = pc_q[7:0];
            cbwic_pkg::SEQ_VEC_LO:  seq_addr  = nmi_type_q ?
                cbwic_pkg::VEC_NMI_LO : cbwic_pkg::VEC_IRQ_LO; // [RULE_13]
            cbwic_pkg::SEQ_VEC_HI:  seq_addr  = nmi_type_q ?
                cbwic_pkg::VEC_NMI_HI : cbwic_pkg::VEC_IRQ_HI; // [RULE_16]
            default:                seq_wdata = status_q;
        endcase
    end

    // bus outputs load at phase-one start unless the cycle is held
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_address_lines       <= cbwic_pkg::ADDR_RST;
            o_data_lines          <= cbwic_pkg::DATA_RST;
            bus_write_q           <= 1'b0;
            o_transfer_direction  <= 1'b1;
            o_opcode_fetch_marker <= 1'b0;
            last_q                <= 1'b0;
        end else if (p1_rise && !hold_q) begin
            if (state_q == cbwic_pkg::SEQ_IDLE) begin
                o_address_lines       <= i_req_addr;
                o_data_lines          <= i_req_wdata;
                bus_write_q           <= i_req_write;
                o_transfer_direction  <= ~i_req_write;   // [RULE_18]
                o_opcode_fetch_marker <= i_req_fetch;    // [RULE_19]
                last_q                <= i_req_last;
            end else begin
                o_address_lines       <= seq_addr;
                o_data_lines          <= seq_wdata;
                bus_write_q           <= ~state_q[2];
                o_transfer_direction  <= state_q[2];     // [RULE_18]
                o_opcode_fetch_marker <= 1'b0;
                last_q                <= 1'b0;
            end
        end
    end

    // drivers on only for a write cycle with the gate high; forced off as a
    // new cycle loads, so a read never inherits the last write's enable
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_data_lines_oe <= 1'b0;
        end else if (p1_rise && !hold_q) begin
            o_data_lines_oe <= 1'b0;                     // [RULE_03]
        end else begin
            o_data_lines_oe <= gate_s & bus_write_q; // [RULE_01] [RULE_02]
        end
    end

    // hold: a read with release low repeats until release is high
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_q   <= 1'b0;
            o_halted <= 1'b0;
        end else if (p2_fall) begin
            hold_q   <= halt_now;                    // [RULE_06] [RULE_07]
            o_halted <= halt_now;
        end
    end

    // non-maskable edge latch; a new edge wins over the clear at start
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_prev_q && !nmi_n_s) begin
            nmi_pend_q <= 1'b1;                      // [RULE_15] [RULE_21]
        end else if (p2_fall && !halt_now && take_int &&
                     state_q == cbwic_pkg::SEQ_IDLE) begin
            nmi_pend_q <= 1'b0;                      // [RULE_21]
        end
    end

    // core handshake: one pulse per completed core cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cycle_done <= 1'b0;
            o_read_data  <= cbwic_pkg::DATA_RST;
        end else begin
            o_cycle_done <= p2_fall & ~halt_now &
                            (state_q == cbwic_pkg::SEQ_IDLE);
            if (p2_fall && !bus_write_q && !halt_now) begin
                o_read_data <= data_s;
            end
        end
    end

    // interrupt sequencer advances once per completed bus cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q      <= cbwic_pkg::SEQ_IDLE;
            nmi_type_q   <= 1'b0;
            sp_q         <= 8'h00;
            status_q     <= 8'h00;
            pc_q         <= 16'h0000;
            o_new_pc     <= 16'h0000;
            o_seq_active <= 1'b0;
            o_sp_dec     <= 1'b0;
            o_set_mask   <= 1'b0;
            o_pc_load    <= 1'b0;
        end else begin
            o_sp_dec   <= 1'b0;
            o_set_mask <= 1'b0;
            o_pc_load  <= 1'b0;
            if (p2_fall && !halt_now) begin
                case (state_q)
                    cbwic_pkg::SEQ_IDLE: begin
                        if (take_int) begin             // [RULE_17]
                            state_q      <= cbwic_pkg::SEQ_PUSH_HI;
                            nmi_type_q   <= nmi_pend_q; // [RULE_16]
                            sp_q         <= i_core_sp;
                            status_q     <= i_core_status;
                            pc_q         <= i_core_pc;
                            o_seq_active <= 1'b1;
                        end
                    end
                    cbwic_pkg::SEQ_PUSH_HI: begin
                        state_q  <= cbwic_pkg::SEQ_PUSH_LO;
                        sp_q     <= sp_q - 8'h01;
                        o_sp_dec <= 1'b1;
                    end
                    cbwic_pkg::SEQ_PUSH_LO: begin
                        state_q  <= cbwic_pkg::SEQ_PUSH_ST;
                        sp_q     <= sp_q - 8'h01;
                        o_sp_dec <= 1'b1;
                    end
                    cbwic_pkg::SEQ_PUSH_ST: begin
                        state_q    <= cbwic_pkg::SEQ_VEC_LO;
                        sp_q       <= sp_q - 8'h01;
                        o_sp_dec   <= 1'b1;
                        o_set_mask <= 1'b1;             // [RULE_12]
                    end
                    cbwic_pkg::SEQ_VEC_LO: begin
                        state_q       <= cbwic_pkg::SEQ_VEC_HI;
                        o_new_pc[7:0] <= data_s;        // [RULE_13]
                    end
                    cbwic_pkg::SEQ_VEC_HI: begin
                        state_q        <= cbwic_pkg::SEQ_IDLE;
                        o_new_pc[15:8] <= data_s;
                        o_pc_load      <= 1'b1;
                        o_seq_active   <= 1'b0;
                    end
                    default: state_q <= cbwic_pkg::SEQ_IDLE;
                endcase
            end
        end
    end

    AST_GATE_LOW_OFF: assert property (                 // [RULE_02]
        @(posedge i_clk) disable iff (i_rst)
        !gate_s |=> !o_data_lines_oe)
        else $error("drivers on with gate low");
    AST_READ_OFF: assert property (                     // [RULE_03]
        @(posedge i_clk) disable iff (i_rst)
        o_data_lines_oe |-> !o_transfer_direction)
        else $error("drivers on during read");
    AST_HALT_HOLDS_ADDR: assert property (              // [RULE_06]
        @(posedge i_clk) disable iff (i_rst)
        (p1_rise && hold_q) |=> o_halted && $stable(o_address_lines))
        else $error("halt did not hold the address");
    AST_HALT_NO_DONE: assert property (                 // [RULE_07]
        @(posedge i_clk) disable iff (i_rst)
        (p2_fall && !bus_write_q && !rel_s) |=> !o_cycle_done)
        else $error("cycle completed while release low");
    AST_WRITE_NO_HALT: assert property (                // [RULE_08]
        @(posedge i_clk) disable iff (i_rst)
        (p2_fall && bus_write_q) |=> !o_halted)
        else $error("write cycle halted");
    AST_MASK_AFTER_PUSH: assert property (              // [RULE_12]
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_set_mask) |-> $past(state_q) == cbwic_pkg::SEQ_PUSH_ST
        && state_q == cbwic_pkg::SEQ_VEC_LO)
        else $error("mask set outside status push");
    AST_IRQ_VECTOR: assert property (                   // [RULE_13]
        @(posedge i_clk) disable iff (i_rst)
        (p1_rise && !hold_q && state_q == cbwic_pkg::SEQ_VEC_LO
         && !nmi_type_q) |=> o_address_lines == 16'hFFFE)
        else $error("wrong maskable vector address");
    AST_NMI_VECTOR: assert property (                   // [RULE_16]
        @(posedge i_clk) disable iff (i_rst)
        (p1_rise && !hold_q && state_q == cbwic_pkg::SEQ_VEC_HI
         && nmi_type_q) |=> o_address_lines == 16'hFFFB)
        else $error("wrong non-maskable vector address");
    AST_NO_INT_HALTED: assert property (                // [RULE_14]
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_seq_active) |-> $past(rel_s))
        else $error("interrupt taken with release low");
    AST_NMI_LATCH: assert property (                    // [RULE_21]
        @(posedge i_clk) disable iff (i_rst)
        (nmi_prev_q && !nmi_n_s) |=> nmi_pend_q)
        else $error("non-maskable edge lost");
    AST_FETCH_IS_READ: assert property (                // [RULE_19]
        @(posedge i_clk) disable iff (i_rst)
        o_opcode_fetch_marker |-> o_transfer_direction)
        else $error("fetch marker on a write");
endmodule : cbwic_top

// ---- hdl/cbwic_pkg.sv ----
// Behaviour
// RULE_01: eight-bit two-way data lines, three-state drivers
// RULE_02: data drivers on only while gate high
// RULE_03: read cycles never drive data lines
// RULE_04: system should tie gate to phase two
// RULE_05: system supplies two non-overlapping clock phases
// RULE_06: halt release low in read halts, address held
// RULE_07: stay halted until halt release returns high
// RULE_08: writes complete; halt deferred to next read
// RULE_09: halt release must not change during phase two
// RULE_10: maskable request taken after instruction, mask clear
// RULE_11: push program counter and status onto stack
// RULE_12: set interrupt mask after saving state
// RULE_13: maskable vector read from FFFE then FFFF
// RULE_14: no interrupt recognised while halt release low
// RULE_15: falling non-maskable input requests non-maskable sequence
// RULE_16: non-maskable ignores mask, vector FFFA then FFFB
// RULE_17: sample requests in phase two, start next phase one
// RULE_18: direction high for reads, low for writes
// RULE_19: fetch marker high from phase one of fetch
// RULE_20: maskable request is active-low level, stays pending
// RULE_21: one non-maskable sequence per latched falling edge
package cbwic_pkg;
    // sampled input vector layout
    localparam int IN_W       = 14;
    localparam int IN_P1      = 13;
    localparam int IN_P2      = 12;
    localparam int IN_GATE    = 11;
    localparam int IN_REL     = 10;
    localparam int IN_IRQ     = 9;
    localparam int IN_NMI     = 8;
    localparam int IN_DATA_LO = 0;
    // idle levels: halt release, both request pins high
    localparam logic [13:0] IN_RST = 14'h0700;

    localparam logic [7:0]  STACK_PAGE  = 8'h01;
    localparam logic [15:0] VEC_IRQ_LO  = 16'hFFFE;
    localparam logic [15:0] VEC_IRQ_HI  = 16'hFFFF;
    localparam logic [15:0] VEC_NMI_LO  = 16'hFFFA;
    localparam logic [15:0] VEC_NMI_HI  = 16'hFFFB;
    localparam logic [15:0] ADDR_RST    = 16'h0000;
    localparam logic [7:0]  DATA_RST    = 8'h00;

    // interrupt sequencer, gray coded from SEQ_IDLE to SEQ_VEC_HI; the return to idle flips all three bits
    typedef enum logic [2:0] {
        SEQ_IDLE    = 3'h0,
        SEQ_PUSH_HI = 3'h1,
        SEQ_PUSH_LO = 3'h3,
        SEQ_PUSH_ST = 3'h2,
        SEQ_VEC_LO  = 3'h6,
        SEQ_VEC_HI  = 3'h7
    } cbwic_seq_t;
endpackage : cbwic_pkg

// ---- hdl/cbwic_sync.sv ----
`timescale 1ns/10ps
// three-stage sampler; a change is accepted once stages two and three agree
module cbwic_sync #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    input  wire logic [W-1:0]   i_async,
    output logic      [W-1:0]   o_sync
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // first stage feeds only the second, to keep metastability contained
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_q   <= RST_VAL;
            s2_q   <= RST_VAL;
            s3_q   <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    o_sync[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : cbwic_sync

// ---- tb/cbwic_mem_model.sv ----
`timescale 1ns/10ps
// far side: phase clocks, data gate, ready line and byte-wide memory
module cbwic_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_hold,
    input  wire logic        i_gate_off,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_dir,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_oe,
    output logic             o_p1,
    output logic             o_p2,
    output logic             o_gate,
    output logic             o_rel,
    output logic      [7:0]  o_rdata
);
    logic [7:0] mem [0:65535];
    logic [4:0] ph_q;
    logic [7:0] last_q;

    // fill memory with an address-derived pattern
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = a[7:0] ^ a[15:8] ^ 8'hA5;
        end
    end

    // twenty-clock cycle; the long gap lets the core present its next request
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) ph_q <= 5'h00;
        else ph_q <= (ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
    end
    assign o_p1   = !i_rst && ph_q > 5'h00 && ph_q < 5'h07;
    assign o_p2   = ph_q > 5'h07 && ph_q < 5'h0E;
    assign o_gate = o_p2 && !i_gate_off;

    // ready only moves at the start of phase one, never in phase two
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) o_rel <= 1'b1;
        else if (ph_q == 5'h00) o_rel <= !i_hold;
    end

    // read data driven through phase two plus a short hold; else it churns
    assign o_rdata = (i_dir && ph_q > 5'h07 && ph_q < 5'h10) ?
                     mem[i_addr] : ~last_q;
    always @(posedge i_clk) begin
        last_q <= o_rdata;
        if (ph_q == 5'h0E && !i_dir) mem[i_addr] <= i_oe ? i_wdata : ~last_q;
    end
endmodule : cbwic_mem_model

// ---- tb/test_cbwic_top.sv ----
`timescale 1ns/10ps
// bench for bus cycles, wait states and interrupt entry
module test_cbwic_top;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        hold = 1'b0, gate_off = 1'b0, irq_n = 1'b1, nmi_n = 1'b1;
    logic        p1, p2, gate, rel, oe, dir, mark, done, halted, seq, load;
    logic        sp_dec, set_mask, r_write = 1'b0, r_fetch = 1'b1;
    logic        r_last = 1'b0, core_mask = 1'b1, clr_mask = 1'b0;
    logic [7:0]  din, dout, rd, r_wdata = 8'h00, sp = 8'hFD;
    logic [15:0] addr, new_pc, got_pc, r_addr = 16'h0200, pc = 16'h1234;
    logic        saw_oe, saw_rd_oe, saw_seq;
    int          bad_count = 0, check_count = 0, cyc = 0;

    always #25 i_clk = ~i_clk;

    cbwic_mem_model u_mem (.i_clk(i_clk), .i_rst(i_rst), .i_hold(hold),
        .i_gate_off(gate_off), .i_addr(addr), .i_dir(dir), .i_wdata(dout),
        .i_oe(oe), .o_p1(p1), .o_p2(p2), .o_gate(gate), .o_rel(rel),
        .o_rdata(din));

    cbwic_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_phase_one_clock(p1),
        .i_phase_two_clock(p2), .i_data_output_gate(gate),
        .i_halt_release(rel), .i_maskable_irq_n(irq_n),
        .i_nonmaskable_irq_n(nmi_n), .i_data_lines(din),
        .o_data_lines(dout), .o_data_lines_oe(oe), .o_address_lines(addr),
        .o_transfer_direction(dir), .o_opcode_fetch_marker(mark),
        .i_req_addr(r_addr), .i_req_write(r_write), .i_req_wdata(r_wdata),
        .i_req_fetch(r_fetch), .i_req_last(r_last), .i_core_pc(pc),
        .i_core_status(8'hC3), .i_core_sp(sp), .i_core_mask(core_mask),
        .o_cycle_done(done), .o_read_data(rd), .o_halted(halted),
        .o_seq_active(seq), .o_sp_dec(sp_dec), .o_set_mask(set_mask),
        .o_pc_load(load), .o_new_pc(new_pc));

    // core side reaction to the sequencer pulses
    always @(posedge i_clk) begin
        if (sp_dec === 1'b1) sp <= sp - 8'h01;
        if (set_mask === 1'b1) core_mask <= 1'b1;
        else if (clr_mask) core_mask <= 1'b0;
        if (load === 1'b1) pc <= new_pc;
    end

    // hang guard: the whole run needs well under this many clocks
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : pat

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // next core cycle; write data derived from the address
    task automatic put_req(input logic [15:0] a, input logic w,
                           input logic f, input logic l);
        @(posedge i_clk);
        r_addr <= a;
        r_write <= w;
        r_wdata <= a[7:0] ^ 8'h3C;
        r_fetch <= f;
        r_last <= l;
    endtask : put_req

    // wait for cycle end, logging what was seen meanwhile
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        saw_oe = 1'b0;
        saw_rd_oe = 1'b0;
        saw_seq = 1'b0;
        do begin
            @(negedge i_clk);
            n++;
            if (oe === 1'b1) saw_oe = 1'b1;
            if (oe === 1'b1 && dir === 1'b1) saw_rd_oe = 1'b1;
            if (seq === 1'b1) saw_seq = 1'b1;
            if (load === 1'b1) got_pc = new_pc;
        end while (done !== 1'b1 && n < lim);
    endtask : wait_done

    task automatic t_rw;
        put_req(16'h0234, 1'b0, 1'b1, 1'b0);
        wait_done(60);
        chk("read dir", 16'h1, dir);
        chk("fetch mark", 16'h1, mark);
        chk("read data", pat(16'h0234), rd);
        chk("read oe", 16'h0, saw_rd_oe);
        put_req(16'h0345, 1'b1, 1'b0, 1'b0);
        wait_done(60);
        chk("write dir", 16'h0, dir);
        chk("write mark", 16'h0, mark);
        chk("write oe", 16'h1, saw_oe);
        chk("mem", 16'h79, u_mem.mem[16'h0345]);
        gate_off <= 1'b1;
        put_req(16'h0346, 1'b1, 1'b0, 1'b0);
        wait_done(60);
        chk("gated oe", 16'h0, saw_oe);
        gate_off <= 1'b0;
        $display("test rw finished");
    endtask : t_rw

    task automatic t_halt;
        @(posedge i_clk) hold <= 1'b1;
        put_req(16'h0456, 1'b0, 1'b1, 1'b0);
        wait_done(100);
        chk("held done", 16'h0, done);
        chk("halted", 16'h1, halted);
        chk("held addr", 16'h0456, addr);
        hold <= 1'b0;
        wait_done(100);
        chk("resume done", 16'h1, done);
        chk("resume data", pat(16'h0456), rd);
        @(posedge i_clk) hold <= 1'b1;
        put_req(16'h0567, 1'b1, 1'b0, 1'b0);
        wait_done(60);
        chk("write done", 16'h1, done);
        chk("write mem", 16'h5B, u_mem.mem[16'h0567]);
        put_req(16'h0678, 1'b0, 1'b0, 1'b0);
        wait_done(60);
        chk("deferred halt", 16'h1, halted);
        hold <= 1'b0;
        wait_done(100);
        chk("deferred done", 16'h1, done);
        $display("test halt finished");
    endtask : t_halt

    task automatic t_irq;
        @(posedge i_clk) irq_n <= 1'b0;
        put_req(16'h0700, 1'b0, 1'b0, 1'b1);
        wait_done(60);
        put_req(16'h0701, 1'b0, 1'b1, 1'b0);
        wait_done(200);
        chk("masked seq", 16'h0, saw_seq);
        @(posedge i_clk) clr_mask <= 1'b1;
        @(posedge i_clk) clr_mask <= 1'b0;
        put_req(16'h0702, 1'b0, 1'b0, 1'b1);
        wait_done(60);
        put_req(16'h0703, 1'b0, 1'b1, 1'b0);
        wait_done(200);
        chk("irq seq", 16'h1, saw_seq);
        chk("push pc hi", 16'h12, u_mem.mem[16'h01FD]);
        chk("push pc lo", 16'h34, u_mem.mem[16'h01FC]);
        chk("push st", 16'hC3, u_mem.mem[16'h01FB]);
        chk("sp", 16'hFA, sp);
        chk("mask", 16'h1, core_mask);
        chk("irq vec", {pat(16'hFFFF), pat(16'hFFFE)}, got_pc);
        @(posedge i_clk) irq_n <= 1'b1;
        $display("test irq finished");
    endtask : t_irq

    task automatic t_nmi;
        @(posedge i_clk) nmi_n <= 1'b0;
        put_req(16'h0800, 1'b0, 1'b0, 1'b1);
        wait_done(60);
        put_req(16'h0801, 1'b0, 1'b1, 1'b0);
        wait_done(200);
        chk("nmi seq", 16'h1, saw_seq);
        chk("nmi vec", {pat(16'hFFFB), pat(16'hFFFA)}, got_pc);
        put_req(16'h0802, 1'b0, 1'b0, 1'b1);
        wait_done(60);
        put_req(16'h0803, 1'b0, 1'b1, 1'b0);
        wait_done(200);
        chk("one per edge", 16'h0, saw_seq);
        @(posedge i_clk) nmi_n <= 1'b1;
        $display("test nmi finished");
    endtask : t_nmi

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        wait_done(100);
        t_rw();
        t_halt();
        t_irq();
        t_nmi();
        wrap_up();
    end
endmodule : test_cbwic_top
